/* design/sipr_pkg.sv */
// Package for the serial source priority control register block.
// Assumes a 32-bit Avalon-MM slave with word addressing inside the block.
package sipr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0]  SIPR_ADDR_PRIO   = 4'h0;  // Priority register
  localparam logic [3:0]  SIPR_ADDR_STATUS = 4'h1;  // Enabled-source view
  localparam logic [31:0] SIPR_UNMAPPED    = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int SIPR_UART4_LSB = 12;
  localparam int SIPR_OTG_LSB   = 8;
  localparam int SIPR_TW2_LSB   = 4;
  localparam int SIPR_TW1_LSB   = 0;
  localparam int SIPR_NFIELDS   = 4;
  localparam int SIPR_FIELD_W   = 3;
  localparam int SIPR_FIELD_PITCH = 4;

  localparam logic [2:0]  SIPR_PRIO_RESET = 3'h4;  // Priority 4 at reset
  localparam logic [2:0]  SIPR_PRIO_OFF   = 3'h0;  // Source disabled
  localparam logic [2:0]  SIPR_PRIO_MIN   = 3'h1;  // Lowest enabled
  localparam logic [2:0]  SIPR_PRIO_MAX   = 3'h7;  // Highest
  localparam logic [15:0] SIPR_IMPL_MASK  = 16'h7777;
  localparam logic [15:0] SIPR_REG_RESET  = 16'h4444;

  // ----------------------------------------------------------------
  // State carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] prio;       // Stored priority register
    logic [31:0] rdata;      // Registered read data
    logic        ack;        // Access answered this cycle
  } sipr_state_s;

endpackage : sipr_pkg

/* design/sipr_top.sv */
// What this block does
// (RULE1) Bits 14..12 hold the read/write UART4 error priority.
// (RULE2) Bits 10..8 hold the read/write on-the-go controller priority.
// (RULE3) Bits 6..4 hold the read/write channel 2 collision priority.
// (RULE4) Bits 2..0 hold the read/write channel 1 collision priority.
// (RULE5) Code 111 is priority 7, highest; other codes are their level.
// (RULE6) Code 001 is priority 1; code 000 disables the source.
// (RULE7) Reset loads 100 in each field; bits 15,11,7,3 read zero.
//
// File holds the register slice with its Avalon-MM slave.
// Assumes a master that holds requests until waitrequest is low.
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps

module sipr_top
  import sipr_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic [2:0]       uart_ch4_error_priority_o,
  output logic [2:0]       otg_controller_priority_o,
  output logic [2:0]       twowire_ch2_collision_priority_o,
  output logic [2:0]       twowire_ch1_collision_priority_o,
  output logic [3:0]       source_enabled_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sipr_state_s st_r;
  sipr_state_s st_nxt;
  logic [3:0]  en_w;

  // A code of zero keeps the source from ever requesting service
  function automatic logic prio_enabled(input logic [2:0] p);
    prio_enabled = (p != SIPR_PRIO_OFF);  // [RULE6]
  endfunction : prio_enabled

  // Enable view, one bit per field
  genvar g;
  generate
    for (g = 0; g < SIPR_NFIELDS; g++) begin : g_en
      assign en_w[g] = prio_enabled(
        st_r.prio[g*SIPR_FIELD_PITCH +: SIPR_FIELD_W]);  // [RULE5] [RULE6]
    end
  endgenerate

  // Next state: one wait cycle on every access keeps read data registered.
  // The read word is captured on the accepting edge; a write lands only on
  // the following edge, the one at which the master sees waitrequest low.
  always_comb begin
    logic [15:0] wmask;
    wmask  = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    // Unimplemented bits never store  [RULE1] [RULE2] [RULE3] [RULE4]
    if (avs_write_i && st_r.ack && avs_address_i == SIPR_ADDR_PRIO) begin
      st_nxt.prio = (st_r.prio & ~(wmask & SIPR_IMPL_MASK)) |
                    (avs_writedata_i[15:0] & wmask &
                     SIPR_IMPL_MASK);  // [RULE7]
    end
    if ((avs_read_i || avs_write_i) && !st_r.ack) begin
      st_nxt.ack = 1'b1;
      st_nxt.rdata = SIPR_UNMAPPED;
      if (avs_read_i) begin
        case (avs_address_i)
          SIPR_ADDR_PRIO: begin
            st_nxt.rdata = {16'h0000, st_r.prio & SIPR_IMPL_MASK};  // [RULE7]
          end
          SIPR_ADDR_STATUS: begin
            st_nxt.rdata = {28'h0000000, en_w};
          end
          default: begin
            st_nxt.rdata = SIPR_UNMAPPED;
          end
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_r.prio  <= SIPR_REG_RESET;  // [RULE7]
      st_r.rdata <= SIPR_UNMAPPED;
      st_r.ack   <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata_o    = st_r.rdata;
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !st_r.ack;
  assign uart_ch4_error_priority_o =
    st_r.prio[SIPR_UART4_LSB +: SIPR_FIELD_W];  // [RULE1]
  assign otg_controller_priority_o =
    st_r.prio[SIPR_OTG_LSB +: SIPR_FIELD_W];  // [RULE2]
  assign twowire_ch2_collision_priority_o =
    st_r.prio[SIPR_TW2_LSB +: SIPR_FIELD_W];  // [RULE3]
  assign twowire_ch1_collision_priority_o =
    st_r.prio[SIPR_TW1_LSB +: SIPR_FIELD_W];  // [RULE4]
  assign source_enabled_o = en_w;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Request seen while not yet answered: the accepting edge
  sequence acc_take_s;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence

  // No request on the bus this cycle
  sequence bus_idle_s;
    !avs_read_i && !avs_write_i;
  endsequence

  // Completing write to the priority word with both low lanes enabled
  sequence prio_wr_s;
    avs_write_i && !avs_waitrequest_o &&
    avs_address_i == SIPR_ADDR_PRIO && (&avs_byteenable_i[1:0]);
  endsequence

  // Completing reads of the two mapped words
  sequence prio_rd_s;
    avs_read_i && !avs_waitrequest_o && avs_address_i == SIPR_ADDR_PRIO;
  endsequence

  sequence stat_rd_s;
    avs_read_i && !avs_waitrequest_o && avs_address_i == SIPR_ADDR_STATUS;
  endsequence

  // UART4 error field follows a full write on the next edge
  uart_field_a: assert property ( // [RULE1]
    @(posedge clk_sys_i) disable iff (rst_i)
    prio_wr_s |=> uart_ch4_error_priority_o ==
      $past(avs_writedata_i[SIPR_UART4_LSB +: SIPR_FIELD_W]))
    else $error("uart field not written");

  // On-the-go controller field follows a full write on the next edge
  otg_field_a: assert property ( // [RULE2]
    @(posedge clk_sys_i) disable iff (rst_i)
    prio_wr_s |=> otg_controller_priority_o ==
      $past(avs_writedata_i[SIPR_OTG_LSB +: SIPR_FIELD_W]))
    else $error("otg field not written");

  // Channel 2 collision field follows a full write on the next edge
  tw2_field_a: assert property ( // [RULE3]
    @(posedge clk_sys_i) disable iff (rst_i)
    prio_wr_s |=> twowire_ch2_collision_priority_o ==
      $past(avs_writedata_i[SIPR_TW2_LSB +: SIPR_FIELD_W]))
    else $error("channel 2 field not written");

  // Channel 1 collision field follows a full write on the next edge
  tw1_field_a: assert property ( // [RULE4]
    @(posedge clk_sys_i) disable iff (rst_i)
    prio_wr_s |=> twowire_ch1_collision_priority_o ==
      $past(avs_writedata_i[SIPR_TW1_LSB +: SIPR_FIELD_W]))
    else $error("channel 1 field not written");

  // Highest code always leaves the source enabled
  max_enabled_a: assert property ( // [RULE5]
    @(posedge clk_sys_i) disable iff (rst_i)
    uart_ch4_error_priority_o == SIPR_PRIO_MAX |-> source_enabled_o[3])
    else $error("priority 7 not enabled");

  // Code zero, and only code zero, silences the source
  off_disabled_a: assert property ( // [RULE6]
    @(posedge clk_sys_i) disable iff (rst_i)
    (twowire_ch1_collision_priority_o == SIPR_PRIO_OFF) ==
      !source_enabled_o[0])
    else $error("disable code mismatch");

  // Lowest enabled code still requests service
  min_enabled_a: assert property ( // [RULE6]
    @(posedge clk_sys_i) disable iff (rst_i)
    otg_controller_priority_o == SIPR_PRIO_MIN |-> source_enabled_o[2])
    else $error("priority 1 not enabled");

  // Spare bits of the priority word always read back as zero
  unimpl_zero_a: assert property ( // [RULE7]
    @(posedge clk_sys_i) disable iff (rst_i)
    prio_rd_s |-> (avs_readdata_o & ~{16'h0000, SIPR_IMPL_MASK}) ==
      32'h0000_0000)
    else $error("unimplemented bits not zero");

  // Every field comes out of reset at priority 4
  reset_value_a: assert property ( // [RULE7]
    @(posedge clk_sys_i)
    $fell(rst_i) |->
      {uart_ch4_error_priority_o, otg_controller_priority_o,
       twowire_ch2_collision_priority_o, twowire_ch1_collision_priority_o}
      == {SIPR_NFIELDS{SIPR_PRIO_RESET}})
    else $error("reset priority wrong");

  // Every access is answered after exactly one wait cycle
  wait_once_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    acc_take_s |=> !avs_waitrequest_o)
    else $error("waitrequest held too long");

  // An idle bus never sees waitrequest
  idle_no_wait_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    bus_idle_s |-> !avs_waitrequest_o)
    else $error("waitrequest raised while idle");

  // Read word shows each field in its own place, spare bits zero
  prio_read_a: assert property ( // [RULE1] [RULE2] [RULE3] [RULE4]
    @(posedge clk_sys_i) disable iff (rst_i)
    prio_rd_s |-> avs_readdata_o[15:0] ==
      {1'b0, uart_ch4_error_priority_o, 1'b0, otg_controller_priority_o,
       1'b0, twowire_ch2_collision_priority_o,
       1'b0, twowire_ch1_collision_priority_o})
    else $error("priority word does not match fields");

  // Enable view read back matches the enable outputs
  stat_read_a: assert property ( // [RULE5] [RULE6]
    @(posedge clk_sys_i) disable iff (rst_i)
    stat_rd_s |-> avs_readdata_o == {28'h0000000, source_enabled_o})
    else $error("enable view does not match outputs");

  // Upper half of every read word is zero
  upper_zero_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:16] == 16'h0000)
    else $error("upper read bits not zero");

  // Priorities move only on the edge at which a priority write completes;
  // a write landing on the accepting edge would trip this
  prio_hold_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    !(avs_write_i && !avs_waitrequest_o &&
      avs_address_i == SIPR_ADDR_PRIO) |=>
      $stable({uart_ch4_error_priority_o, otg_controller_priority_o,
               twowire_ch2_collision_priority_o,
               twowire_ch1_collision_priority_o}))
    else $error("priority changed without a write");

  // Read data stand unchanged while the bus is idle
  rdata_hold_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    bus_idle_s |=> $stable(avs_readdata_o))
    else $error("read data changed while idle");

endmodule : sipr_top

/* sim/serial_irq_priority_reg_tb.sv */
// Self-checking bench for the serial source priority register slice.
// Assumes sipr_pkg and sipr_top are compiled first; one 50 MHz clock.
`timescale 1ns/1ps
module serial_irq_priority_reg_tb;
  import sipr_pkg::*;
  // ----------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------
  logic        clk_sys_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        rd        = 1'b0;
  logic        wr        = 1'b0;
  logic [3:0]  adr       = 4'h0;
  logic [3:0]  be        = 4'hf;
  logic [31:0] wd        = 32'h0;
  logic [31:0] rdat, q, d;
  logic [3:0]  b, en;
  logic [2:0]  p3, p2, p1, p0;
  logic        wt;
  logic [15:0] m;
  int          err_total = 0;
  int          n_compared = 0;
  int          seed = 55;
  wire  [15:0] ov = {1'b0, p3, 1'b0, p2, 1'b0, p1, 1'b0, p0};
  sipr_top i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt), .uart_ch4_error_priority_o(p3),
    .otg_controller_priority_o(p2), .twowire_ch2_collision_priority_o(p1),
    .twowire_ch1_collision_priority_o(p0), .source_enabled_o(en));
  always #10 clk_sys_i = ~clk_sys_i;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Expected register after a write; spare bits always read zero
  function automatic logic [15:0] upd(input logic [15:0] o,
      input logic [31:0] x, input logic [3:0] y);
    if (y[0]) o[7:0] = x[7:0];
    if (y[1]) o[15:8] = x[15:8];
    return o & 16'h7777;
  endfunction : upd
  function automatic logic [3:0] ena(input logic [15:0] v);
    return {|v[14:12], |v[10:8], |v[6:4], |v[2:0]};
  endfunction : ena
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  // Request rises just after an edge and is held until the edge at which
  // waitrequest is seen low; read data are taken at that same edge, and
  // only the watchdog ends a wait that never finishes
  task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] x, input logic [3:0] y);
    @(posedge clk_sys_i);
    rd  <= !w;
    wr  <= w;
    adr <= a;
    wd  <= x;
    be  <= y;
    do begin
      @(posedge clk_sys_i);
    end while (wt !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic check_all();
    bus(1'b0, SIPR_ADDR_PRIO, 32'h0, 4'hf);
    chk({16'h0, m}, q);
    chk({16'h0, m}, {16'h0, ov});
    chk({28'h0, ena(m)}, {28'h0, en});
    bus(1'b0, SIPR_ADDR_STATUS, 32'h0, 4'hf);
    chk({28'h0, ena(m)}, q);
  endtask : check_all
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    m = 16'h4444;
    check_all();
    $display("reset values done");
    // Every code in every field, with random bits everywhere else
    for (int f = 0; f < 4; f++) begin
      for (int c = 0; c < 8; c++) begin
        d = $random(seed);
        d[4*f +: 3] = c[2:0];
        bus(1'b1, SIPR_ADDR_PRIO, d, 4'hf);
        m = upd(m, d, 4'hf);
        check_all();
      end
    end
    $display("field code sweep done");
    // Random byte-lane writes must keep the untouched lane
    repeat (20) begin
      d = $random(seed);
      b = 4'($random(seed));
      bus(1'b1, SIPR_ADDR_PRIO, d, b);
      m = upd(m, d, b);
      check_all();
    end
    $display("partial writes done");
    // Writes to the status word or an unmapped place change nothing
    bus(1'b1, SIPR_ADDR_STATUS, 32'hffff_ffff, 4'hf);
    bus(1'b1, 4'h9, 32'h0, 4'hf);
    check_all();
    bus(1'b0, 4'h9, 32'hffff_ffff, 4'hf);
    chk(32'h0, q);
    $display("refused accesses done");
    // All ones: every field at 7, spare bits must still read zero
    bus(1'b1, SIPR_ADDR_PRIO, 32'hffff_ffff, 4'hf);
    m = upd(m, 32'hffff_ffff, 4'hf);
    check_all();
    // Reset in mid-run puts every field back to priority 4
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    m = 16'h4444;
    check_all();
    $display("mid-run reset done");
    end_of_test();
  end
  // Whole run is well under a thousand cycles; this limit is far beyond it
  initial begin
    #500_000;
    err_total++;
    end_of_test();
  end
endmodule : serial_irq_priority_reg_tb
